// >>> logic/fats_sequencer.sv
module fats_sequencer #(
  parameter int ADC_W = 14,
  parameter int ACC_W = 24
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_I,
  // register port
  input wire logic [fats_pkg::ADDR_W-1:0] REG_ADDR_I,
  input wire logic [fats_pkg::DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [fats_pkg::DATA_W-1:0] REG_RDATA_O,
  // sample control
  input wire logic SLOT_START_I,
  output logic SEQ_BUSY_O,
  output logic ACTIVE_SLOT_B_O,
  // analog front end
  input wire logic [1:0] CATHODE_DEFAULT_I,
  output logic PD_CONNECT_O,
  output logic [1:0] CATHODE_SEL_O,
  output logic [1:0] AMP_REF_O,
  output logic [fats_pkg::DATA_W-1:0] AFE_CFG_O,
  output logic INT_RESET_O,
  output logic INT_POS_O,
  output logic INT_NEG_O,
  output logic INT_HOLD_O,
  // converter
  input wire logic [ADC_W-1:0] ADC_DATA_I,
  input wire logic ADC_DONE_I,
  output logic ADC_SAMPLE_O,
  // result
  output logic [ACC_W-1:0] RESULT_O,
  output logic RESULT_SLOT_B_O,
  output logic RESULT_VALID_O
);
  import fats_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register file

  // maps an offset to {hit, index}; unmapped offsets give no hit
  function automatic logic [4:0] reg_slot(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_LED_SEL: reg_slot = 5'h10;
      OFS_A_TIM: reg_slot = 5'h11;
      OFS_A_CNT: reg_slot = 5'h12;
      OFS_B_TIM: reg_slot = 5'h13;
      OFS_B_CNT: reg_slot = 5'h14;
      OFS_PER_HI: reg_slot = 5'h15;
      OFS_A_INT: reg_slot = 5'h16;
      OFS_B_INT: reg_slot = 5'h17;
      OFS_A_REF: reg_slot = 5'h18;
      OFS_A_AFE: reg_slot = 5'h19;
      OFS_B_REF: reg_slot = 5'h1a;
      OFS_B_AFE: reg_slot = 5'h1b;
      OFS_CATH: reg_slot = 5'h1c;
      OFS_MATH: reg_slot = 5'h1d;
      OFS_B_FLT: reg_slot = 5'h1e;
      OFS_A_FLT: reg_slot = 5'h1f;
      default: reg_slot = 5'h00;
    endcase
  endfunction

  // converts a microsecond field to fine units of 6.25 ns
  function automatic logic [T_W-1:0] us_to_fine(input logic [9:0] us);
    return T_W'(us) * FINE_PER_US;
  endfunction

  logic [DATA_W-1:0] regs [16];
  logic [4:0] acc_slot;
  logic reg_hit;
  logic [3:0] reg_idx;

  assign acc_slot = reg_slot(REG_ADDR_I);
  assign reg_hit = acc_slot[4];
  assign reg_idx = acc_slot[3:0];

  // writes store the whole word; reads of unmapped offsets return zero
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < 16; i++) begin
        regs[i] <= REG_RESET;
      end
      REG_RDATA_O <= REG_RESET;
    end else begin
      if (REG_WR_I && reg_hit) begin
        regs[reg_idx] <= REG_WDATA_I;
      end
      if (REG_RD_I) begin
        REG_RDATA_O <= reg_hit ? regs[reg_idx] : REG_RESET;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-slot field selection

  fats_state_type state;
  fats_state_type next_state;
  fats_int_type istate;
  fats_int_type next_istate;
  logic slot_b;
  logic [DATA_W-1:0] r_tim, r_cnt, r_int, r_flt, r_ref, r_afe;
  logic [1:0] sel_f, en_f, math_f, cath_f, per_hi;
  logic [4:0] precon_us, conw_us, iw_us;
  logic [7:0] off_us, pcnt;
  logic [9:0] per_us;
  logic [10:0] ist;
  logic float_on;

  // one set of fields per slot; the slot flag picks which set drives timing
  assign r_tim = slot_b ? regs[4'h3] : regs[4'h1];
  assign r_cnt = slot_b ? regs[4'h4] : regs[4'h2];
  assign r_int = slot_b ? regs[4'h7] : regs[4'h6];
  assign r_ref = slot_b ? regs[4'ha] : regs[4'h8];
  assign r_afe = slot_b ? regs[4'hb] : regs[4'h9];
  assign r_flt = slot_b ? regs[4'he] : regs[4'hf];
  assign sel_f = slot_b ? regs[4'h0][SEL_B_LSB +: 2] : regs[4'h0][SEL_A_LSB +: 2];
  assign per_hi = slot_b ? regs[4'h5][PER_HI_B_LSB +: 2] : regs[4'h5][PER_HI_A_LSB +: 2];
  assign math_f = slot_b ? regs[4'hd][MATH_B_LSB +: 2] : regs[4'hd][MATH_A_LSB +: 2];
  assign cath_f = slot_b ? regs[4'hc][CATH_B_LSB +: 2] : regs[4'hc][CATH_A_LSB +: 2];
  assign en_f = r_flt[FLT_EN_LSB +: 2];
  assign precon_us = r_flt[PRECON_LSB +: 5];
  assign conw_us = r_tim[CONW_LSB +: 5];
  assign off_us = r_tim[OFF_LSB +: 8];
  assign pcnt = r_cnt[PCNT_LSB +: 8];
  assign per_us = {per_hi, r_cnt[PER_LO_LSB +: 8]};
  assign iw_us = r_int[IW_LSB +: 5];
  assign ist = r_int[IST_LSB +: 11];
  assign float_on = (sel_f == SEL_FLOAT) && (en_f == FLT_EN_ON);

  ////////////////////////////////////////////////////////////////////////////
  // event times within the current pulse, in fine units

  logic [T_W-1:0] t, t_next, ic, ic_next;
  logic [T_W-1:0] precon_fine, conw_fine, off_fine, per_fine, iw_fine;
  logic [T_W-1:0] int_start_fine, lead, conn_at, conn_end, pos_at;
  logic [7:0] pulse_idx, fired_cnt, done_cnt;
  logic first_pulse, last_pulse;

  assign precon_fine = us_to_fine(10'(precon_us));
  assign conw_fine = us_to_fine(10'(conw_us));
  assign off_fine = us_to_fine(10'(off_us));
  assign per_fine = us_to_fine(per_us);
  assign iw_fine = us_to_fine(10'(iw_us));
  // start field plus fixed front end latency gives the positive phase start
  assign int_start_fine = T_W'(ist) * FINE_PER_STEP + INT_LATENCY_FINE;
  assign lead = (off_fine > int_start_fine) ? off_fine - int_start_fine : '0;
  assign first_pulse = (pulse_idx == 8'h00);
  assign last_pulse = ((pulse_idx + 8'h01) == pcnt);
  // only pulse one may be short; later floats all last the period
  assign conn_at = first_pulse ? off_fine : per_fine;
  assign conn_end = conn_at + conw_fine;
  // the integrator keeps its lead on the dump in every pulse that fires on time and whose float is at least the lead
  assign pos_at = (conn_at > lead) ? conn_at - lead : '0;
  assign t_next = t + FINE_STEP;
  assign ic_next = ic + FINE_STEP;

  ////////////////////////////////////////////////////////////////////////////
  // pulse sequencer

  logic running, fire, take, subtract, restart;

  assign running = (state == S_PRECON) || (state == S_FLOAT) ||
                   (state == S_CONNECT) || (state == S_DRAIN);
  // a late pulse is still integrated once the integrator frees up, so no
  // result is lost, but its window then no longer lines up with the dump
  assign fire = running && (istate == I_IDLE) && (fired_cnt != pcnt) &&
                ((state == S_DRAIN) || (fired_cnt < pulse_idx) || (t >= pos_at));
  assign take = (istate == I_HOLD) && ADC_DONE_I;
  assign subtract = (math_f == MATH_SUB_ADD) && (done_cnt == 8'h00);
  assign restart = (state == S_LAUNCH) ||
                   ((state == S_CONNECT) && (next_state == S_FLOAT));

  // next sequencer state
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: begin
        if (SLOT_START_I) begin
          next_state = S_LAUNCH;
        end
      end
      S_LAUNCH: begin
        if (float_on && (pcnt != 8'h00)) begin
          next_state = S_PRECON;
        end else if (slot_b) begin
          next_state = S_IDLE;
        end
      end
      S_PRECON: begin
        if (t_next >= precon_fine) begin
          next_state = S_FLOAT;
        end
      end
      S_FLOAT: begin
        if (t_next >= conn_at) begin
          next_state = S_CONNECT;
        end
      end
      S_CONNECT: begin
        if (t_next >= conn_end) begin
          next_state = last_pulse ? S_DRAIN : S_FLOAT;
        end
      end
      S_DRAIN: begin
        if ((done_cnt == pcnt) && (istate == I_IDLE)) begin
          next_state = slot_b ? S_IDLE : S_LAUNCH;
        end
      end
    endcase
  end

  // pulse time base and slot bookkeeping
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      state <= S_IDLE;
      t <= '0;
      slot_b <= 1'b0;
      pulse_idx <= 8'h00;
    end else begin
      state <= next_state;
      t <= restart ? '0 : t_next;
      if (state == S_IDLE) begin
        slot_b <= 1'b0;
      end else if (next_state == S_LAUNCH) begin
        slot_b <= (state == S_LAUNCH) || (state == S_DRAIN);
      end
      if (state == S_LAUNCH) begin
        pulse_idx <= 8'h00;
      end else if ((state == S_CONNECT) && (next_state != S_CONNECT)) begin
        pulse_idx <= pulse_idx + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // integrator phases and accumulation

  always_comb begin
    next_istate = istate;
    unique case (istate)
      I_IDLE: begin
        if (fire) begin
          next_istate = I_CLEAR;
        end
      end
      I_CLEAR: next_istate = I_POS;
      I_POS: begin
        if (ic_next >= iw_fine) begin
          next_istate = I_NEG;
        end
      end
      I_NEG: begin
        if (ic_next >= iw_fine) begin
          next_istate = I_HOLD;
        end
      end
      I_HOLD: begin
        if (ADC_DONE_I) begin
          next_istate = I_IDLE;
        end
      end
    endcase
  end

  // counters restart at each slot; the sum is signed two's complement
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      istate <= I_IDLE;
      ic <= '0;
      fired_cnt <= 8'h00;
      done_cnt <= 8'h00;
      RESULT_O <= '0;
    end else begin
      istate <= next_istate;
      ic <= (istate != next_istate) ? '0 : ic_next;
      if (state == S_LAUNCH) begin
        fired_cnt <= 8'h00;
        done_cnt <= 8'h00;
        RESULT_O <= '0;
      end else begin
        if (fire) begin
          fired_cnt <= fired_cnt + 8'h01;
        end
        if (take) begin
          done_cnt <= done_cnt + 8'h01;
          RESULT_O <= subtract ? RESULT_O - ACC_W'(ADC_DATA_I)
                               : RESULT_O + ACC_W'(ADC_DATA_I);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog controls and status

  // PD_CONNECT_O and RESULT_VALID_O are registered from next states so they switch with the state; RESULT_SLOT_B_O takes slot_b,
  // CATHODE_SEL_O takes CATHODE_DEFAULT_I unless the override bit is set, the rest follow the registers
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      PD_CONNECT_O <= 1'b0;
      CATHODE_SEL_O <= 2'h0;
      AMP_REF_O <= 2'h0;
      AFE_CFG_O <= REG_RESET;
      RESULT_VALID_O <= 1'b0;
      RESULT_SLOT_B_O <= 1'b0;
    end else begin
      PD_CONNECT_O <= (next_state == S_PRECON) || (next_state == S_CONNECT);
      CATHODE_SEL_O <= regs[4'hc][CATH_OVR_BIT] ? cath_f : CATHODE_DEFAULT_I;
      AMP_REF_O <= r_ref[REF_LSB +: 2];
      AFE_CFG_O <= r_afe;
      RESULT_VALID_O <= (state == S_DRAIN) && (next_state != S_DRAIN);
      if ((state == S_DRAIN) && (next_state != S_DRAIN)) begin
        RESULT_SLOT_B_O <= slot_b;
      end
    end
  end

  // phase strobes decode the integrator state flops
  assign INT_RESET_O = (istate == I_CLEAR);
  assign INT_POS_O = (istate == I_POS);
  assign INT_NEG_O = (istate == I_NEG);
  assign INT_HOLD_O = (istate == I_HOLD);
  assign ADC_SAMPLE_O = (istate == I_NEG) && (next_istate == I_HOLD);
  assign SEQ_BUSY_O = (state != S_IDLE);
  assign ACTIVE_SLOT_B_O = slot_b;
endmodule

// >>> pkg/fats_pkg.sv
package fats_pkg;
  // register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_LED_SEL = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_A_TIM = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_A_CNT = 8'h31;
  localparam logic [ADDR_W-1:0] OFS_B_TIM = 8'h35;
  localparam logic [ADDR_W-1:0] OFS_B_CNT = 8'h36;
  localparam logic [ADDR_W-1:0] OFS_PER_HI = 8'h37;
  localparam logic [ADDR_W-1:0] OFS_A_INT = 8'h39;
  localparam logic [ADDR_W-1:0] OFS_B_INT = 8'h3b;
  localparam logic [ADDR_W-1:0] OFS_A_REF = 8'h42;
  localparam logic [ADDR_W-1:0] OFS_A_AFE = 8'h43;
  localparam logic [ADDR_W-1:0] OFS_B_REF = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_B_AFE = 8'h45;
  localparam logic [ADDR_W-1:0] OFS_CATH = 8'h54;
  localparam logic [ADDR_W-1:0] OFS_MATH = 8'h58;
  localparam logic [ADDR_W-1:0] OFS_B_FLT = 8'h59;
  localparam logic [ADDR_W-1:0] OFS_A_FLT = 8'h5e;

  // field positions and widths
  localparam int SEL_A_LSB = 0;
  localparam int SEL_B_LSB = 2;
  localparam int FLT_EN_LSB = 13;
  localparam int PRECON_LSB = 8;
  localparam int PER_LO_LSB = 0;
  localparam int PER_HI_A_LSB = 0;
  localparam int PER_HI_B_LSB = 8;
  localparam int CONW_LSB = 8;
  localparam int OFF_LSB = 0;
  localparam int IW_LSB = 11;
  localparam int IST_LSB = 0;
  localparam int PCNT_LSB = 8;
  localparam int MATH_A_LSB = 1;
  localparam int MATH_B_LSB = 5;
  localparam int REF_LSB = 4;
  localparam int CATH_OVR_BIT = 7;
  localparam int CATH_A_LSB = 8;
  localparam int CATH_B_LSB = 10;

  // field codes
  localparam logic [1:0] SEL_FLOAT = 2'h0;
  localparam logic [1:0] FLT_EN_ON = 2'h3;
  localparam logic [1:0] MATH_SUB_ADD = 2'h2;

  // timing, fine unit is 6.25 ns so both 1 us and 31.25 ns are whole counts
  localparam int T_W = 18;
  localparam int CLK_PERIOD_PS = 100000;
  localparam int FINE_PS = 6250;
  localparam int US_PS = 1000000;
  localparam int STEP_PS = 31250;
  localparam int INT_LATENCY_PS = 9250000;
  localparam logic [T_W-1:0] FINE_STEP = T_W'(CLK_PERIOD_PS / FINE_PS);
  localparam logic [T_W-1:0] FINE_PER_US = T_W'(US_PS / FINE_PS);
  localparam logic [T_W-1:0] FINE_PER_STEP = T_W'(STEP_PS / FINE_PS);
  localparam logic [T_W-1:0] INT_LATENCY_FINE = T_W'(INT_LATENCY_PS / FINE_PS);

  // sequencer and integrator states
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_LAUNCH = 6'b000010,
    S_PRECON = 6'b000100,
    S_FLOAT = 6'b001000,
    S_CONNECT = 6'b010000,
    S_DRAIN = 6'b100000
  } fats_state_type;

  typedef enum logic [4:0] {
    I_IDLE = 5'b00001,
    I_CLEAR = 5'b00010,
    I_POS = 5'b00100,
    I_NEG = 5'b01000,
    I_HOLD = 5'b10000
  } fats_int_type;
endpackage

// >>> sim/fats_sequencer_monitor.sv
module fats_monitor #(
  parameter int ACC_W = 24
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_I,
  // watched ports
  input wire logic SLOT_START_I,
  input wire logic SEQ_BUSY_O,
  input wire logic PD_CONNECT_O,
  input wire logic INT_RESET_O,
  input wire logic INT_POS_O,
  input wire logic INT_NEG_O,
  input wire logic INT_HOLD_O,
  input wire logic ADC_DONE_I,
  input wire logic ADC_SAMPLE_O,
  input wire logic [ACC_W-1:0] RESULT_O,
  input wire logic RESULT_VALID_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock domain, reset aborts every attempt
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);
  ////////////////////////////////////////
  // integrator steps of one float pulse
  sequence s_clear_pos;
    INT_RESET_O ##1 INT_POS_O;
  endsequence
  sequence s_neg_hold;
    INT_NEG_O ##1 (INT_HOLD_O && !INT_NEG_O);
  endsequence
  property p_clear_pos;
    INT_RESET_O |-> s_clear_pos;
  endproperty
  a_clear_pos: assert property (p_clear_pos) else $error("no positive phase after clear");
  property p_pos_neg;
    $fell(INT_POS_O) |-> INT_NEG_O;
  endproperty
  a_pos_neg: assert property (p_pos_neg) else $error("positive phase not followed by negative");
  property p_sample_hold;
    ADC_SAMPLE_O |-> s_neg_hold;
  endproperty
  a_sample_hold: assert property (p_sample_hold) else $error("sample not at end of negative");
  property p_hold_wait;
    INT_HOLD_O && !ADC_DONE_I |=> INT_HOLD_O;
  endproperty
  a_hold_wait: assert property (p_hold_wait) else $error("hold dropped before conversion");
  property p_phases;
    !(INT_POS_O && (INT_NEG_O || INT_HOLD_O || INT_RESET_O));
  endproperty
  a_phases: assert property (p_phases) else $error("integrator phases overlap");
  ////////////////////////////////////////
  // sequence control and result
  property p_start_busy;
    SLOT_START_I && !SEQ_BUSY_O |=> SEQ_BUSY_O;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start in idle not taken");
  property p_valid_pulse;
    RESULT_VALID_O |=> !RESULT_VALID_O;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("result valid longer than one");
  // idle keeps the result and leaves the diode floating
  property p_idle_quiet;
    !SEQ_BUSY_O ##1 !SEQ_BUSY_O |-> $stable(RESULT_O) && !PD_CONNECT_O;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("activity while idle");
endmodule
bind fats_sequencer fats_monitor #(.ACC_W(ACC_W)) u_fats_monitor (.MCLK_I(MCLK_I),
  .RST_I(RST_I), .SLOT_START_I(SLOT_START_I), .SEQ_BUSY_O(SEQ_BUSY_O),
  .PD_CONNECT_O(PD_CONNECT_O), .INT_RESET_O(INT_RESET_O), .INT_POS_O(INT_POS_O),
  .INT_NEG_O(INT_NEG_O), .INT_HOLD_O(INT_HOLD_O), .ADC_DONE_I(ADC_DONE_I),
  .ADC_SAMPLE_O(ADC_SAMPLE_O), .RESULT_O(RESULT_O), .RESULT_VALID_O(RESULT_VALID_O));

// >>> sim/fats_afe_model.sv
module fats_afe_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // integrator side
  input wire logic sample_i,
  input wire logic hold_i,
  input wire logic [13:0] code_i,
  input wire logic [7:0] delay_i,
  // converter result
  output logic done_o,
  output logic [13:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] wait_cnt;
  ////////////////////////////////////////
  // conversion delay, zero means nothing pending; answers only while held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_cnt <= 9'h000;
      done_o <= 1'b0;
      data_o <= 14'h0000;
    end else begin
      done_o <= 1'b0;
      data_o <= ~data_o; // toggles so stale data never looks valid
      if (sample_i) begin
        wait_cnt <= {1'b0, delay_i} + 9'h001;
      end else if (wait_cnt == 9'h001 && hold_i) begin
        wait_cnt <= 9'h000;
        done_o <= 1'b1;
        data_o <= code_i;
      end else if (wait_cnt > 9'h001) begin
        wait_cnt <= wait_cnt - 9'h001;
      end
    end
  end
endmodule

// >>> sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fats_pkg::*;
  logic mclk, busy, act_b, pd, i_rst, i_pos, i_neg, i_hold;
  logic adc_done, adc_smp, res_b, res_v, pd_q = 1'b0;
  logic rst = 1'b1, wr = 1'b0, rd = 1'b0, start = 1'b0;
  logic [7:0] addr = 8'h00, dly = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata, afe, v;
  logic [1:0] cath_def = 2'h1, cath, aref, exp_cath;
  logic [13:0] code = 14'h0000, adc_data;
  logic [23:0] result;
  logic [13:0] aq[$];
  int rq[$], fq[$];
  int fail_count, check_count, cyc, nvalid, npulse, exp_slot, exp_arith, sum, t, npos, nneg;
  integer seed = 32'hb7b10ab6;
  logic [7:0] ofs [16] = '{OFS_LED_SEL, OFS_A_TIM, OFS_A_CNT, OFS_B_TIM, OFS_B_CNT, OFS_PER_HI,
    OFS_A_INT, OFS_B_INT, OFS_A_REF, OFS_A_AFE, OFS_B_REF, OFS_B_AFE, OFS_CATH, OFS_MATH,
    OFS_B_FLT, OFS_A_FLT};
  fats_sequencer u_fats_sequencer (
    .MCLK_I(mclk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .SLOT_START_I(start), .SEQ_BUSY_O(busy),
    .ACTIVE_SLOT_B_O(act_b), .CATHODE_DEFAULT_I(cath_def), .PD_CONNECT_O(pd),
    .CATHODE_SEL_O(cath), .AMP_REF_O(aref), .AFE_CFG_O(afe), .INT_RESET_O(i_rst),
    .INT_POS_O(i_pos), .INT_NEG_O(i_neg), .INT_HOLD_O(i_hold), .ADC_DATA_I(adc_data),
    .ADC_DONE_I(adc_done), .ADC_SAMPLE_O(adc_smp), .RESULT_O(result),
    .RESULT_SLOT_B_O(res_b), .RESULT_VALID_O(res_v));
  fats_afe_model u_fats_afe_model (.clk_i(mclk), .rst_i(rst), .sample_i(adc_smp),
    .hold_i(i_hold), .code_i(code), .delay_i(dly), .done_o(adc_done), .data_o(adc_data));
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // bus tasks start one edge later so a strobe is never set and cleared at one edge
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    check("register", 24'(rdata), 24'(e));
  endtask
  // one sample period; a second start while busy must be ignored
  task automatic run(input int sb, pre, off, wid, per, n, ar, input logic [1:0] ce);
    exp_slot = sb;
    npulse = n;
    exp_arith = ar;
    exp_cath = ce;
    rq.delete();
    fq.delete();
    aq.delete();
    nvalid = 0;
    @(posedge mclk);
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    repeat (5) @(posedge mclk);
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    t = 0;
    while (busy !== 1'b0 && t < 30000) begin
      @(posedge mclk);
      t++;
    end
    // the closing valid pulse is counted at this same edge, so let it land first
    @(posedge mclk);
    if (t >= 30000) begin
      fail_count++;
      print_verdict();
    end
    check("valid", 24'(nvalid), 24'h1);
    check("edges", 24'(rq.size()), 24'(n + 1));
    check("precondition", 24'(fq[0] - rq[0]), 24'(pre * 10));
    check("float one", 24'(fq[1] - fq[0]), 24'((off + wid - pre) * 10));
    for (int k = 1; k <= n; k++) begin
      check("connect", 24'(fq[k] - rq[k]), 24'(wid * 10));
      if (k < n) check("period", 24'(rq[k + 1] - fq[k]), 24'(per * 10));
    end
  endtask
  ////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // fresh converter code every cycle, latched by the model at done
  always @(posedge mclk) begin
    code <= 14'($random(seed));
  end
  // reference model: diode edges, conversions and the expected sum
  always @(posedge mclk) begin
    cyc++;
    if (pd === 1'b1 && pd_q === 1'b0) begin
      rq.push_back(cyc);
      check("afe", 24'(afe), 24'hae65);
      check("ref", 24'(aref), 24'h2);
      check("cathode", 24'(cath), 24'(exp_cath));
      check("slot", 24'(act_b), 24'(exp_slot));
    end
    if (pd === 1'b0 && pd_q === 1'b1) fq.push_back(cyc);
    // both integration phases last the programmed 3 us window
    if (i_pos === 1'b1) begin
      npos++;
    end else if (npos != 0) begin
      check("positive phase", 24'(npos), 24'(3 * 10));
      npos = 0;
    end
    if (i_neg === 1'b1) begin
      nneg++;
    end else if (nneg != 0) begin
      check("negative phase", 24'(nneg), 24'(3 * 10));
      nneg = 0;
    end
    if (adc_done && i_hold) aq.push_back(adc_data);
    if (res_v === 1'b1) begin
      nvalid++;
      sum = 0;
      foreach (aq[k]) sum += (k == 0 && exp_arith == 2) ? -int'(aq[k]) : int'(aq[k]);
      check("result", result, 24'(sum));
      check("pulses", 24'(aq.size()), 24'(npulse));
      check("result slot", 24'(res_b), 24'(exp_slot));
    end
    pd_q = pd;
  end
  // main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    foreach (ofs[i]) rd_chk(ofs[i], 16'h0000);
    foreach (ofs[i]) begin
      v = 16'($random(seed));
      wr_reg(ofs[i], v);
      rd_chk(ofs[i], v);
    end
    wr_reg(8'h7f, 16'hffff);
    rd_chk(8'h7f, 16'h0000);
    wr_reg(OFS_PER_HI, 16'h0201);
    wr_reg(OFS_A_REF, 16'h0020);
    wr_reg(OFS_B_REF, 16'h0020);
    wr_reg(OFS_A_AFE, 16'hae65);
    wr_reg(OFS_B_AFE, 16'hae65);
    wr_reg(OFS_A_FLT, 16'h6400);
    wr_reg(OFS_B_FLT, 16'h6500);
    wr_reg(OFS_A_TIM, 16'h0214);
    wr_reg(OFS_B_TIM, 16'h0216);
    wr_reg(OFS_A_CNT, 16'h0204);
    wr_reg(OFS_B_CNT, 16'h030a);
    wr_reg(OFS_A_INT, 16'h18f8);
    wr_reg(OFS_B_INT, 16'h1938);
    // slot A alone, prompt converter, first pulse subtracted
    wr_reg(OFS_LED_SEL, 16'h000c);
    wr_reg(OFS_CATH, 16'h0280);
    wr_reg(OFS_MATH, 16'h0004);
    run(0, 4, 20, 2, 260, 2, 2, 2'h2);
    // slot B alone, slow converter, three pulses summed, default cathode
    wr_reg(OFS_LED_SEL, 16'h0003);
    wr_reg(OFS_CATH, 16'h0800);
    wr_reg(OFS_MATH, 16'h0000);
    cath_def <= 2'h3;
    dly <= 8'h28;
    run(1, 5, 22, 2, 522, 3, 0, 2'h3);
    print_verdict();
  end
endmodule
